// file: ial_core.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - add or subtract register or immediate into destination, byte/word/long
// - byte subtract of an immediate is refused
// - add/subtract with carry flag, byte operands only
// - step up/down by 1 or 2; byte steps by 1 only
// - wide small add/sub of 1, 2 or 4 on longword only
// - decimal adjust byte after add or subtract using flags
// - unsigned multiply 8x8 to 16 or 16x16 to 32
// - signed multiply with the same widths
// - unsigned divide 16/8 or 32/16, quotient low, remainder high
// - signed divide with the same widths
// - compare subtracts, updates flags only, destination kept
// - negate replaces destination with zero minus it
// - zero extend low byte to word or low word to long
// - sign extend low byte to word or low word to long
// - and, or, xor with register or immediate, any size
// - one's complement of destination at the chosen size
// - arithmetic shifts keep sign on right shift
// - logical shifts fill vacated bit with zero
// - rotates move the outgoing bit to the other end
// - rotate through carry: old carry in, outgoing bit becomes carry
// - carry holds add carry, subtract borrow, shifted-out bit
module ial_core (
    input  wire logic                      ref_clk_in,
    input  wire logic                      nrst_in,
    input  wire logic                      ce_in,
    input  wire logic                      req_in,
    input  wire logic [4:0]                op_in,
    input  wire logic [1:0]                size_in,
    input  wire logic                      imm_sel_in,
    input  wire logic [31:0]               dst_in,
    input  wire logic [31:0]               src_in,
    input  wire logic [31:0]               imm_in,
    input  wire logic [ial_pkg::FLAG_W-1:0] flags_in,
    output logic                           done_out,
    output logic                           wr_en_out,
    output logic                           illegal_out,
    output logic [31:0]                    result_out,
    output logic [ial_pkg::FLAG_W-1:0]     flags_out,
    input  wire logic [3:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest
);
    logic [4:0]                msb;
    logic [31:0]               mask;
    logic [31:0]               opnd;
    logic [31:0]               a;
    logic [31:0]               b;
    logic                      cin;
    logic                      is_sub;
    logic [32:0]               ar;
    logic [31:0]               hx;
    logic                      ar_c;
    logic                      ar_v;
    logic                      ar_h;
    logic [32:0]               sh;
    logic                      sh_out;
    logic                      ins;
    logic [7:0]                bcd;
    logic                      bcd_c;
    logic [31:0]               mulv;
    logic [31:0]               divv;
    logic                      div0;
    logic                      ill;
    logic                      wr;
    logic [31:0]               next_res;
    logic [ial_pkg::FLAG_W-1:0] next_flg;
    logic                      ctrl_en;
    logic                      bus_ack;
    logic                      last_ill;
    logic [ial_pkg::CNT_W-1:0] op_cnt;
    logic                      take;

    // operand width by size
    always_comb begin
        unique case (size_in)
            ial_pkg::SZ_W: begin
                msb  = ial_pkg::MSB_W;
                mask = ial_pkg::MASK_W;
            end
            ial_pkg::SZ_L: begin
                msb  = ial_pkg::MSB_L;
                mask = ial_pkg::MASK_L;
            end
            default: begin
                msb  = ial_pkg::MSB_B;
                mask = ial_pkg::MASK_B;
            end
        endcase
    end

    // adder operands: second operand, step constant or negate
    always_comb begin
        opnd   = imm_sel_in ? imm_in : src_in;
        a      = dst_in & mask;
        b      = opnd & mask;
        cin    = 1'b0;
        is_sub = 1'b0;
        unique case (op_in)
            ial_pkg::OP_SUB,
            ial_pkg::OP_CMP: is_sub = 1'b1;
            ial_pkg::OP_ADDC: cin = flags_in[ial_pkg::FLG_C];
            ial_pkg::OP_SUBC: begin
                cin    = flags_in[ial_pkg::FLG_C];
                is_sub = 1'b1;
            end
            ial_pkg::OP_INC,
            ial_pkg::OP_ADDS: b = {29'h0, imm_in[2:0]};
            ial_pkg::OP_DCR,
            ial_pkg::OP_WSUB: begin
                b      = {29'h0, imm_in[2:0]};
                is_sub = 1'b1;
            end
            ial_pkg::OP_NEG: begin
                a      = 32'h0;
                b      = dst_in & mask;
                is_sub = 1'b1;
            end
            default: is_sub = 1'b0;
        endcase
    end

    // carry or borrow from the adder
    always_comb begin
        if (is_sub) begin
            ar = {1'b0, a} - {1'b0, b} - {32'h0, cin};
        end else begin
            ar = {1'b0, a} + {1'b0, b} + {32'h0, cin};
        end
        hx   = a ^ b ^ ar[31:0];
        ar_h = hx[msb - ial_pkg::HALF_OFS];
        ar_c = ar[6'(msb) + 6'h01];
        if (is_sub) begin
            ar_v = (a[msb] != b[msb]) && (ar[msb] != a[msb]);
        end else begin
            ar_v = (a[msb] == b[msb]) && (ar[msb] != a[msb]);
        end
    end

    always_comb begin
        ins = 1'b0;
        if (op_in[0] == 1'b0) begin
            sh_out = a[msb];
            unique case (op_in)
                ial_pkg::OP_ROL: ins = a[msb];
                ial_pkg::OP_RCL: ins = flags_in[ial_pkg::FLG_C];
                default: ins = 1'b0;
            endcase
            sh = {a, ins};
        end else begin
            sh_out = a[0];
            unique case (op_in)
                ial_pkg::OP_ASR: ins = a[msb];
                ial_pkg::OP_ROR: ins = a[0];
                ial_pkg::OP_RCR: ins = flags_in[ial_pkg::FLG_C];
                default: ins = 1'b0;
            endcase
            sh = {1'b0, a >> 1} | ({32'h0, ins} << msb);
        end
    end

    // decimal adjust on the low byte
    always_comb begin
        bcd   = dst_in[7:0];
        bcd_c = flags_in[ial_pkg::FLG_C];
        if (op_in == ial_pkg::OP_BCDA) begin
            if (flags_in[ial_pkg::FLG_H] || (dst_in[3:0] > ial_pkg::BCD_DIG_MAX)) begin
                bcd = bcd + ial_pkg::BCD_LO_ADJ;
            end
            if (flags_in[ial_pkg::FLG_C] || (dst_in[7:0] > ial_pkg::BCD_BYTE_MAX)) begin
                bcd   = bcd + ial_pkg::BCD_HI_ADJ;
                bcd_c = 1'b1;
            end
        end else begin
            if (flags_in[ial_pkg::FLG_H]) begin
                bcd = bcd - ial_pkg::BCD_LO_ADJ;
            end
            if (flags_in[ial_pkg::FLG_C]) begin
                bcd = bcd - ial_pkg::BCD_HI_ADJ;
            end
        end
    end

    // multiply and divide, byte or word form
    always_comb begin
        div0 = 1'b0;
        mulv = 32'h0;
        divv = 32'h0;
        if (size_in == ial_pkg::SZ_B) begin
            div0 = (src_in[7:0] == 8'h00);
            if (op_in == ial_pkg::OP_MULU) begin
                mulv = dst_in[7:0] * src_in[7:0];
            end else begin
                mulv = $signed(dst_in[7:0]) * $signed(src_in[7:0]);
            end
            if (!div0 && op_in == ial_pkg::OP_DIVU) begin
                divv = {16'h0, 8'(dst_in[15:0] % {8'h0, src_in[7:0]}),
                        8'(dst_in[15:0] / {8'h0, src_in[7:0]})};
            end else if (!div0) begin
                divv = {16'h0,
                        8'($signed(dst_in[15:0]) % $signed({{8{src_in[7]}}, src_in[7:0]})),
                        8'($signed(dst_in[15:0]) / $signed({{8{src_in[7]}}, src_in[7:0]}))};
            end
        end else begin
            div0 = (src_in[15:0] == 16'h0);
            if (op_in == ial_pkg::OP_MULU) begin
                mulv = dst_in[15:0] * src_in[15:0];
            end else begin
                mulv = $signed(dst_in[15:0]) * $signed(src_in[15:0]);
            end
            if (!div0 && op_in == ial_pkg::OP_DIVU) begin
                divv = {16'(dst_in % {16'h0, src_in[15:0]}),
                        16'(dst_in / {16'h0, src_in[15:0]})};
            end else if (!div0) begin
                divv = {16'($signed(dst_in) % $signed({{16{src_in[15]}}, src_in[15:0]})),
                        16'($signed(dst_in) / $signed({{16{src_in[15]}}, src_in[15:0]}))};
            end
        end
    end

    // refused size and operand combinations
    always_comb begin
        ill = (size_in == 2'h3) || (op_in > ial_pkg::OP_RCR) || !ctrl_en;
        unique case (op_in)
            ial_pkg::OP_SUB: ill = ill || (imm_sel_in && size_in == ial_pkg::SZ_B);
            ial_pkg::OP_ADDC,
            ial_pkg::OP_SUBC,
            ial_pkg::OP_BCDA,
            ial_pkg::OP_BCDS: ill = ill || (size_in != ial_pkg::SZ_B);
            ial_pkg::OP_INC,
            ial_pkg::OP_DCR: ill = ill || !((imm_in[2:0] == ial_pkg::STEP_1) ||
                ((imm_in[2:0] == ial_pkg::STEP_2) && (size_in != ial_pkg::SZ_B)));
            ial_pkg::OP_ADDS,
            ial_pkg::OP_WSUB: ill = ill || (size_in != ial_pkg::SZ_L) ||
                !((imm_in[2:0] == ial_pkg::STEP_1) || (imm_in[2:0] == ial_pkg::STEP_2) ||
                  (imm_in[2:0] == ial_pkg::STEP_4));
            ial_pkg::OP_MULU,
            ial_pkg::OP_MULS,
            ial_pkg::OP_DIVU,
            ial_pkg::OP_DIVS: ill = ill || (size_in == ial_pkg::SZ_L);
            ial_pkg::OP_EXTZ,
            ial_pkg::OP_SEXT: ill = ill || (size_in == ial_pkg::SZ_B);
            default: ill = ill;
        endcase
    end

    // result and flag selection
    always_comb begin
        next_res = (dst_in & ~mask) | (ar[31:0] & mask);
        next_flg = flags_in;
        wr       = !ill;
        unique case (op_in)
            // sum or difference with all flags
            ial_pkg::OP_ADD,
            ial_pkg::OP_SUB,
            ial_pkg::OP_ADDC,
            ial_pkg::OP_SUBC,
            ial_pkg::OP_NEG,
            ial_pkg::OP_CMP: begin
                next_flg[ial_pkg::FLG_H] = ar_h;
                next_flg[ial_pkg::FLG_N] = ar[msb];
                next_flg[ial_pkg::FLG_Z] = ((ar[31:0] & mask) == 32'h0);
                next_flg[ial_pkg::FLG_V] = ar_v;
                next_flg[ial_pkg::FLG_C] = ar_c;
                // zero only stays set across a chain
                if (op_in == ial_pkg::OP_ADDC || op_in == ial_pkg::OP_SUBC) begin
                    next_flg[ial_pkg::FLG_Z] = next_flg[ial_pkg::FLG_Z] &&
                                               flags_in[ial_pkg::FLG_Z];
                end
                if (op_in == ial_pkg::OP_CMP) begin
                    wr = 1'b0;
                end
            end
            ial_pkg::OP_INC,
            ial_pkg::OP_DCR: begin
                next_flg[ial_pkg::FLG_N] = ar[msb];
                next_flg[ial_pkg::FLG_Z] = ((ar[31:0] & mask) == 32'h0);
                next_flg[ial_pkg::FLG_V] = ar_v;
            end
            ial_pkg::OP_ADDS,
            ial_pkg::OP_WSUB: next_flg = flags_in;
            ial_pkg::OP_BCDA,
            ial_pkg::OP_BCDS: begin
                next_res = {dst_in[31:8], bcd};
                next_flg[ial_pkg::FLG_N] = bcd[7];
                next_flg[ial_pkg::FLG_Z] = (bcd == 8'h00);
                next_flg[ial_pkg::FLG_C] = bcd_c;
            end
            ial_pkg::OP_MULU,
            ial_pkg::OP_MULS: begin
                next_res = (size_in == ial_pkg::SZ_B) ? {dst_in[31:16], mulv[15:0]} : mulv;
                if (op_in == ial_pkg::OP_MULS) begin
                    next_flg[ial_pkg::FLG_N] = (size_in == ial_pkg::SZ_B) ? mulv[15] : mulv[31];
                    next_flg[ial_pkg::FLG_Z] = (size_in == ial_pkg::SZ_B) ?
                                               (mulv[15:0] == 16'h0) : (mulv == 32'h0);
                end
            end
            // divide by zero leaves destination alone
            ial_pkg::OP_DIVU,
            ial_pkg::OP_DIVS: begin
                next_res = (size_in == ial_pkg::SZ_B) ? {dst_in[31:16], divv[15:0]} : divv;
                next_flg[ial_pkg::FLG_N] = (size_in == ial_pkg::SZ_B) ? src_in[7] : src_in[15];
                next_flg[ial_pkg::FLG_Z] = div0;
                wr = !ill && !div0;
            end
            ial_pkg::OP_EXTZ: begin
                next_res = (size_in == ial_pkg::SZ_W) ? {dst_in[31:16], 8'h00, dst_in[7:0]} :
                                                        {16'h0, dst_in[15:0]};
                next_flg[ial_pkg::FLG_N] = 1'b0;
                next_flg[ial_pkg::FLG_Z] = ((next_res & mask) == 32'h0);
                next_flg[ial_pkg::FLG_V] = 1'b0;
            end
            ial_pkg::OP_SEXT: begin
                next_res = (size_in == ial_pkg::SZ_W) ?
                           {dst_in[31:16], {8{dst_in[7]}}, dst_in[7:0]} :
                           {{16{dst_in[15]}}, dst_in[15:0]};
                next_flg[ial_pkg::FLG_N] = next_res[msb];
                next_flg[ial_pkg::FLG_Z] = ((next_res & mask) == 32'h0);
                next_flg[ial_pkg::FLG_V] = 1'b0;
            end
            ial_pkg::OP_AND,
            ial_pkg::OP_OR,
            ial_pkg::OP_XOR,
            ial_pkg::OP_NOT: begin
                unique case (op_in)
                    ial_pkg::OP_AND: next_res = dst_in & (~mask | b);
                    ial_pkg::OP_OR:  next_res = dst_in | b;
                    ial_pkg::OP_XOR: next_res = dst_in ^ b;
                    default:         next_res = dst_in ^ mask;
                endcase
                next_flg[ial_pkg::FLG_N] = next_res[msb];
                next_flg[ial_pkg::FLG_Z] = ((next_res & mask) == 32'h0);
                next_flg[ial_pkg::FLG_V] = 1'b0;
            end
            // shifts and rotates, one bit out to carry
            default: begin
                next_res = (dst_in & ~mask) | (sh[31:0] & mask);
                next_flg[ial_pkg::FLG_N] = sh[msb];
                next_flg[ial_pkg::FLG_Z] = ((sh[31:0] & mask) == 32'h0);
                next_flg[ial_pkg::FLG_C] = sh_out;
                // left arithmetic shift flags sign change
                next_flg[ial_pkg::FLG_V] = (op_in == ial_pkg::OP_ASL) && (a[msb] != sh[msb]);
            end
        endcase
        if (ill) begin
            next_res = dst_in;
            next_flg = flags_in;
        end
    end

    assign take = ce_in && req_in;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            done_out    <= 1'b0;
            wr_en_out   <= 1'b0;
            illegal_out <= 1'b0;
            result_out  <= 32'h0;
            flags_out   <= '0;
        end else if (ce_in) begin
            done_out    <= req_in;
            wr_en_out   <= req_in && wr;
            illegal_out <= req_in && ill;
            if (req_in) begin
                result_out <= next_res;
                flags_out  <= next_flg;
            end
        end
    end

    // status: last refusal and count of accepted operations
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            last_ill <= 1'b0;
            op_cnt   <= '0;
        end else if (take) begin
            last_ill <= ill;
            if (!ill) begin
                op_cnt <= op_cnt + 1'b1;
            end
        end
    end

    // avalon slave: one wait cycle, then the access completes
    assign avs_waitrequest = (avs_read || avs_write) && !bus_ack;

    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            bus_ack      <= 1'b0;
            avs_readdata <= 32'h0;
            ctrl_en      <= ial_pkg::CTRL_EN_RST;
        end else if (ce_in) begin
            bus_ack <= (avs_read || avs_write) && !bus_ack;
            if (avs_read && !bus_ack) begin
                avs_readdata <= 32'h0;
                if (avs_address == ial_pkg::REG_CTRL) begin
                    avs_readdata[ial_pkg::CTRL_EN_BIT] <= ctrl_en;
                end else if (avs_address == ial_pkg::REG_STAT) begin
                    avs_readdata[ial_pkg::FLAG_W-1:0] <= flags_out;
                    avs_readdata[ial_pkg::STAT_ILL_BIT] <= last_ill;
                    avs_readdata[ial_pkg::STAT_CNT_LSB +: ial_pkg::CNT_W] <= op_cnt;
                end
            end
            if (avs_write && bus_ack && avs_byteenable[0] &&
                avs_address == ial_pkg::REG_CTRL) begin
                ctrl_en <= avs_writedata[ial_pkg::CTRL_EN_BIT];
            end
        end
    end
endmodule
`default_nettype wire

// file: ial_pkg.sv
`default_nettype none
package ial_pkg;
    // operation codes on op_in
    typedef logic [4:0] ial_op_t;
    localparam ial_op_t OP_ADD   = 5'h00;
    localparam ial_op_t OP_SUB   = 5'h01;
    localparam ial_op_t OP_ADDC  = 5'h02;
    localparam ial_op_t OP_SUBC  = 5'h03;
    localparam ial_op_t OP_INC   = 5'h04;
    localparam ial_op_t OP_DCR   = 5'h05;
    localparam ial_op_t OP_ADDS  = 5'h06;
    localparam ial_op_t OP_WSUB  = 5'h07;
    localparam ial_op_t OP_BCDA  = 5'h08;
    localparam ial_op_t OP_BCDS  = 5'h09;
    localparam ial_op_t OP_MULU  = 5'h0a;
    localparam ial_op_t OP_MULS  = 5'h0b;
    localparam ial_op_t OP_DIVU  = 5'h0c;
    localparam ial_op_t OP_DIVS  = 5'h0d;
    localparam ial_op_t OP_CMP   = 5'h0e;
    localparam ial_op_t OP_NEG   = 5'h0f;
    localparam ial_op_t OP_EXTZ  = 5'h10;
    localparam ial_op_t OP_SEXT  = 5'h11;
    localparam ial_op_t OP_AND   = 5'h12;
    localparam ial_op_t OP_OR    = 5'h13;
    localparam ial_op_t OP_XOR   = 5'h14;
    localparam ial_op_t OP_NOT   = 5'h15;
    localparam ial_op_t OP_ASL   = 5'h16;
    localparam ial_op_t OP_ASR   = 5'h17;
    localparam ial_op_t OP_LSL   = 5'h18;
    localparam ial_op_t OP_LSR   = 5'h19;
    localparam ial_op_t OP_ROL   = 5'h1a;
    localparam ial_op_t OP_ROR   = 5'h1b;
    localparam ial_op_t OP_RCL   = 5'h1c;
    localparam ial_op_t OP_RCR   = 5'h1d;
    // operand sizes on size_in
    localparam logic [1:0] SZ_B = 2'h0;
    localparam logic [1:0] SZ_W = 2'h1;
    localparam logic [1:0] SZ_L = 2'h2;
    localparam logic [4:0] MSB_B = 5'h07;
    localparam logic [4:0] MSB_W = 5'h0f;
    localparam logic [4:0] MSB_L = 5'h1f;
    localparam logic [31:0] MASK_B = 32'h000000ff;
    localparam logic [31:0] MASK_W = 32'h0000ffff;
    localparam logic [31:0] MASK_L = 32'hffffffff;
    localparam logic [4:0] HALF_OFS = 5'h03;
    // flag vector layout
    localparam int FLAG_W = 5;
    localparam int FLG_C = 0;
    localparam int FLG_V = 1;
    localparam int FLG_Z = 2;
    localparam int FLG_N = 3;
    localparam int FLG_H = 4;
    // small constants for steps and decimal adjust
    localparam logic [2:0] STEP_1 = 3'h1;
    localparam logic [2:0] STEP_2 = 3'h2;
    localparam logic [2:0] STEP_4 = 3'h4;
    localparam logic [7:0] BCD_LO_ADJ = 8'h06;
    localparam logic [7:0] BCD_HI_ADJ = 8'h60;
    localparam logic [3:0] BCD_DIG_MAX = 4'h9;
    localparam logic [7:0] BCD_BYTE_MAX = 8'h99;
    // register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STAT = 4'h4;
    localparam int CTRL_EN_BIT = 0;
    localparam logic CTRL_EN_RST = 1'b1;
    localparam int STAT_ILL_BIT = 8;
    localparam int STAT_CNT_LSB = 16;
    localparam int CNT_W = 16;
endpackage
`default_nettype wire

// file: ial_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ial_properties (
    input wire logic        ref_clk_in,
    input wire logic        nrst_in,
    input wire logic        ce_in,
    input wire logic        req_in,
    input wire logic [4:0]  op_in,
    input wire logic [1:0]  size_in,
    input wire logic        imm_sel_in,
    input wire logic [31:0] dst_in,
    input wire logic [31:0] src_in,
    input wire logic [31:0] imm_in,
    input wire logic        done_out,
    input wire logic        wr_en_out,
    input wire logic        illegal_out,
    input wire logic [31:0] result_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!nrst_in);
    // taken request, refusal answer, and the relations between them
    sequence s_take; ce_in && req_in; endsequence
    sequence s_ref; done_out && illegal_out && !wr_en_out; endsequence
    property p_done; s_take |=> done_out; endproperty
    a_done: assert property (p_done) else $error("request not answered");
    property p_idle; ce_in && !req_in |=> !done_out && $stable(result_out); endproperty
    a_idle: assert property (p_idle) else $error("answer without request");
    property p_wr; wr_en_out |-> done_out && !illegal_out; endproperty
    a_wr: assert property (p_wr) else $error("write without answer");
    property p_ill; illegal_out |-> s_ref ##0 result_out == $past(dst_in); endproperty
    a_ill: assert property (p_ill) else $error("refusal changed result");
    property p_subb; s_take ##0 op_in == ial_pkg::OP_SUB && size_in == ial_pkg::SZ_B
        && imm_sel_in |=> s_ref; endproperty
    a_subb: assert property (p_subb) else $error("byte immediate subtract taken");
    property p_incb; s_take ##0 op_in == ial_pkg::OP_INC && size_in == ial_pkg::SZ_B
        && imm_in[2:0] == ial_pkg::STEP_2 |=> s_ref; endproperty
    a_incb: assert property (p_incb) else $error("byte step of two taken");
    property p_cmp; s_take ##0 op_in == ial_pkg::OP_CMP |=> done_out && !wr_en_out; endproperty
    a_cmp: assert property (p_cmp) else $error("compare wrote back");
    property p_add; s_take ##0 op_in == ial_pkg::OP_ADD && size_in == ial_pkg::SZ_L && !imm_sel_in
        |=> illegal_out || result_out == $past(dst_in) + $past(src_in); endproperty
    a_add: assert property (p_add) else $error("long add wrong");
endmodule
bind ial_core ial_properties i_props (.ref_clk_in, .nrst_in, .ce_in, .req_in, .op_in, .size_in,
    .imm_sel_in, .dst_in, .src_in, .imm_in, .done_out, .wr_en_out, .illegal_out, .result_out);
`default_nettype wire

// file: ial_regfile.sv
`timescale 1ns/1ps
`default_nettype none
module ial_regfile (
    input  wire logic                       ref_clk_in,
    input  wire logic                       nrst_in,
    input  wire logic                       ld_in,
    input  wire logic [31:0]                ld_val_in,
    input  wire logic                       done_in,
    input  wire logic                       wr_en_in,
    input  wire logic [31:0]                res_in,
    input  wire logic [ial_pkg::FLAG_W-1:0] flg_in,
    output logic      [31:0]                dst_out,
    output logic      [ial_pkg::FLAG_W-1:0] flags_out
);
    // destination written back only when told, flags follow every answer
    always_ff @(posedge ref_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            dst_out <= 32'h0;
            flags_out <= '0;
        end else if (ld_in) begin
            dst_out <= ld_val_in;
            flags_out <= '0;
        end else if (done_in) begin
            dst_out <= wr_en_in ? res_in : dst_out;
            flags_out <= flg_in;
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic ref_clk_in = 1'b0, nrst_in = 1'b0, req = 1'b0, isel = 1'b0, ld = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, done, wr_en, ill, wreq;
    logic [4:0]  op = 5'h0;
    logic [1:0]  sz = 2'h0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] src = 32'h0, wdata = 32'h0, ldv = 32'h0, res, dst, rdata, q;
    logic [4:0]  flg, fin;
    int          fails = 0, samples_checked = 0;
    // clock and the two parties
    always #50 ref_clk_in = ~ref_clk_in;
    ial_core i_ial_core (.ref_clk_in, .nrst_in, .ce_in(1'b1), .req_in(req), .op_in(op),
        .size_in(sz), .imm_sel_in(isel), .dst_in(dst), .src_in(src), .imm_in(src),
        .flags_in(fin), .done_out(done), .wr_en_out(wr_en), .illegal_out(ill), .result_out(res),
        .flags_out(flg), .avs_address(addr), .avs_read, .avs_write, .avs_writedata(wdata),
        .avs_byteenable(4'hf), .avs_readdata(rdata), .avs_waitrequest(wreq));
    ial_regfile i_ial_regfile (.ref_clk_in, .nrst_in, .ld_in(ld), .ld_val_in(ldv), .done_in(done),
        .wr_en_in(wr_en), .res_in(res), .flg_in(flg), .dst_out(dst), .flags_out(fin));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    // one operation: request for one cycle, answer checked in the next
    task automatic run(input ial_pkg::ial_op_t o, input logic [1:0] s, input logic i,
        input logic [31:0] v, input logic [31:0] e, input logic il);
        @(posedge ref_clk_in);
        op <= o;
        sz <= s;
        isel <= i;
        src <= v;
        req <= 1'b1;
        @(posedge ref_clk_in);
        req <= 1'b0;
        @(negedge ref_clk_in);
        chk("done", 32'h1, {31'h0, done});
        chk("illegal", {31'h0, il}, {31'h0, ill});
        chk("result", e, res);
        chk("write", {31'h0, !il && o != ial_pkg::OP_CMP}, {31'h0, wr_en});
    endtask
    // avalon access held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk_in);
        addr <= a;
        avs_write <= w;
        avs_read <= !w;
        wdata <= d;
        do @(posedge ref_clk_in); while (wreq !== 1'b0);
        q = rdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        #200000;
        fails++;
        stop_test();
    end
    // main sequence, destination chained through the register model
    initial begin
        repeat (3) @(posedge ref_clk_in);
        nrst_in <= 1'b1;
        ld <= 1'b1;
        ldv <= 32'h123400ff;
        @(posedge ref_clk_in);
        ld <= 1'b0;
        run(ial_pkg::OP_ADD, 2'h0, 1'b0, 32'h1, 32'h12340000, 1'b0);
        chk("carry", 32'h1, {31'h0, flg[ial_pkg::FLG_C]});
        run(ial_pkg::OP_SUB, 2'h0, 1'b1, 32'h1, 32'h12340000, 1'b1);
        run(ial_pkg::OP_ADDC, 2'h0, 1'b0, 32'h5, 32'h12340006, 1'b0);
        run(ial_pkg::OP_INC, 2'h0, 1'b1, 32'h2, 32'h12340006, 1'b1);
        run(ial_pkg::OP_ADDS, 2'h2, 1'b1, 32'h4, 32'h1234000a, 1'b0);
        run(ial_pkg::OP_CMP, 2'h2, 1'b0, 32'h1234000a, 32'h00000000, 1'b0);
        chk("zero", 32'h1, {31'h0, flg[ial_pkg::FLG_Z]});
        run(ial_pkg::OP_NEG, 2'h0, 1'b0, 32'h0, 32'h123400f6, 1'b0);
        run(ial_pkg::OP_SEXT, 2'h1, 1'b0, 32'h0, 32'h1234fff6, 1'b0);
        run(ial_pkg::OP_EXTZ, 2'h2, 1'b0, 32'h0, 32'h0000fff6, 1'b0);
        run(ial_pkg::OP_NOT, 2'h1, 1'b0, 32'h0, 32'h00000009, 1'b0);
        run(ial_pkg::OP_OR, 2'h2, 1'b1, 32'h80000002, 32'h8000000b, 1'b0);
        run(ial_pkg::OP_ASR, 2'h2, 1'b0, 32'h0, 32'hc0000005, 1'b0);
        run(ial_pkg::OP_ROR, 2'h0, 1'b0, 32'h0, 32'hc0000082, 1'b0);
        chk("carry", 32'h1, {31'h0, flg[ial_pkg::FLG_C]});
        run(ial_pkg::OP_RCL, 2'h0, 1'b0, 32'h0, 32'hc0000005, 1'b0);
        run(ial_pkg::OP_LSR, 2'h2, 1'b0, 32'h0, 32'h60000002, 1'b0);
        run(ial_pkg::OP_MULU, 2'h0, 1'b0, 32'h10, 32'h60000020, 1'b0);
        run(ial_pkg::OP_MULS, 2'h1, 1'b0, 32'hffff, 32'hffffffe0, 1'b0);
        run(ial_pkg::OP_DIVS, 2'h1, 1'b0, 32'h5, 32'hfffefffa, 1'b0);
        run(ial_pkg::OP_DIVU, 2'h1, 1'b0, 32'hffff, 32'hfff9ffff, 1'b0);
        run(ial_pkg::OP_AND, 2'h1, 1'b1, 32'h19, 32'hfff90019, 1'b0);
        run(ial_pkg::OP_ADD, 2'h0, 1'b0, 32'h9, 32'hfff90022, 1'b0);
        run(ial_pkg::OP_BCDA, 2'h0, 1'b0, 32'h0, 32'hfff90028, 1'b0);
        bus(1'b1, ial_pkg::REG_CTRL, 32'h0);
        run(ial_pkg::OP_ADD, 2'h2, 1'b0, 32'h1, 32'hfff90028, 1'b1);
        bus(1'b0, ial_pkg::REG_STAT, 32'h0);
        chk("stat refused", 32'h1, {31'h0, q[ial_pkg::STAT_ILL_BIT]});
        bus(1'b1, ial_pkg::REG_CTRL, 32'h1);
        bus(1'b0, ial_pkg::REG_CTRL, 32'h0);
        chk("ctrl", 32'h1, q);
        bus(1'b0, 4'h8, 32'h0);
        chk("unmapped", 32'h0, q);
        run(ial_pkg::OP_ADD, 2'h2, 1'b0, 32'h1, 32'hfff90029, 1'b0);
        stop_test();
    end
endmodule
`default_nettype wire
